/* File: include/iti_pkg.sv */
package iti_pkg;

    // ==========================================================
    // port addresses
    localparam logic [7:0] ITI_ADDR_COUNT0 = 8'h58;
    localparam logic [7:0] ITI_ADDR_COUNT1 = 8'h5A;
    localparam logic [7:0] ITI_ADDR_COUNT2 = 8'h5C;
    localparam logic [7:0] ITI_ADDR_CTRL   = 8'h5E;

    localparam int ITI_CHANNELS = 3;

    // ==========================================================
    // setup word fields
    localparam int ITI_SEL_HI  = 7;
    localparam int ITI_SEL_LO  = 6;
    localparam int ITI_ACC_HI  = 5;
    localparam int ITI_ACC_LO  = 4;
    localparam int ITI_MODE_HI = 3;
    localparam int ITI_MODE_LO = 1;
    localparam int ITI_BCD_BIT = 0;

    localparam logic [1:0] ITI_SEL_INVALID = 2'h3;
    localparam logic [1:0] ITI_ACC_LATCH   = 2'h0;
    localparam logic [1:0] ITI_ACC_HIGH    = 2'h1;
    localparam logic [1:0] ITI_ACC_LOW     = 2'h2;
    localparam logic [1:0] ITI_ACC_BOTH    = 2'h3;

    // ==========================================================
    // values
    localparam logic [15:0] ITI_ZERO      = 16'h0000;
    localparam logic [15:0] ITI_ONE       = 16'h0001;
    localparam logic [15:0] ITI_TWO       = 16'h0002;
    localparam logic [15:0] ITI_THREE     = 16'h0003;
    localparam logic [7:0]  ITI_BYTE_ZERO = 8'h00;
    localparam logic [7:0]  ITI_CTRL_READ = 8'h00;
    localparam logic [3:0]  ITI_DIGIT_0   = 4'h0;
    localparam logic [3:0]  ITI_DIGIT_1   = 4'h1;
    localparam logic [3:0]  ITI_DIGIT_9   = 4'h9;

    typedef enum logic [2:0] {
        ITI_MODE_TERMINAL,
        ITI_MODE_ONE_SHOT,
        ITI_MODE_RATE,
        ITI_MODE_SQUARE,
        ITI_MODE_SW_STROBE,
        ITI_MODE_HW_STROBE
    } iti_mode_t;

    // ==========================================================
    // helpers
    function automatic iti_mode_t iti_decode_mode(input logic [2:0] code);
        iti_mode_t m;
        unique case (code[1:0])
            2'h0:    m = code[2] ? ITI_MODE_SW_STROBE : ITI_MODE_TERMINAL;
            2'h1:    m = code[2] ? ITI_MODE_HW_STROBE : ITI_MODE_ONE_SHOT;
            2'h2:    m = ITI_MODE_RATE;
            default: m = ITI_MODE_SQUARE;
        endcase
        return m;
    endfunction

    function automatic logic [15:0] iti_dec_one(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        logic        borrow;
        logic [3:0]  d;
        r      = v;
        borrow = 1'b1;
        d      = ITI_DIGIT_0;
        if (!bcd) begin
            r = v - ITI_ONE;
        end else begin
            for (int i = 0; i < 4; i++) begin
                d = v[4*i +: 4];
                if (borrow) begin
                    if (d == ITI_DIGIT_0) begin
                        d = ITI_DIGIT_9;
                    end else begin
                        d      = d - ITI_DIGIT_1;
                        borrow = 1'b0;
                    end
                end
                r[4*i +: 4] = d;
            end
        end
        return r;
    endfunction

endpackage

/* File: logic/iti_edge_detect.sv */
module iti_edge_detect
    import iti_pkg::*;
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);

    logic prev;

    // ==========================================================
    // previous level
    always_ff @(posedge clk) begin
        if (srst) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule // iti_edge_detect

/* File: logic/iti_interval_timer.sv */
// Summary of operation
// - three independent 16-bit down-counters, each on own clock falling edge
// - counters at 58H, 5AH, 5CH; setup word port at 5EH
// - all four ports writable; only the three counter ports readable
// - counting starts only after the full one- or two-byte count is loaded
// - select field 00, 01, 10 picks counter 0, 1, 2; 11 invalid
// - access field: latch, high byte only, low byte only, low then high
// - mode field picks six modes; top bit ignored for modes 2 and 3
// - single-byte loading forces the other byte to zero
// - two reads return live count low then high, counting undisturbed
// - latch command snapshots count; next reads return snapshot low then high
// - mode 0: setup word drives output low; counting follows the load
// - mode 0: output high at zero, held until re-setup or reload
// - mode 0: counter keeps counting past zero, wrapping binary or decimal
// - counter 0 decrements on each falling edge of its slow clock
// - counter 0 output drives interrupt input six in mode 0
// - counters 1 and 2 give software-set square-wave baud clocks
// - square wave even count: step two, half high half low, reload at end
// - square wave odd count: high (N+1)/2 periods, low (N-1)/2 periods
module iti_interval_timer
    import iti_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
)
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic [ADDR_WIDTH-1:0] ioAddr,
    input  wire logic                  ioWrStrobe,
    input  wire logic                  ioRdStrobe,
    input  wire logic [7:0]            ioWrData,
    output logic      [7:0]            ioRdData,
    output logic                       ioRdValid,
    input  wire logic                  tickClock0,
    input  wire logic                  tickClock1,
    input  wire logic                  tickClock2,
    input  wire logic                  triggerGate0,
    input  wire logic                  triggerGate1,
    input  wire logic                  triggerGate2,
    output logic                       terminalCountOutput,
    output logic                       interruptInputSix,
    output logic                       baudClockA,
    output logic                       baudClockB
);

    // ==========================================================
    // elaboration check
    if (ADDR_WIDTH < 8) begin : g_bad_width
        $error("ADDR_WIDTH must be at least 8");
    end

    // ==========================================================
    // channel state
    logic [15:0] count   [ITI_CHANNELS], next_count   [ITI_CHANNELS];
    logic [15:0] reload  [ITI_CHANNELS], next_reload  [ITI_CHANNELS];
    logic [15:0] latched [ITI_CHANNELS], next_latched [ITI_CHANNELS];
    logic [7:0]  lowHold [ITI_CHANNELS], next_lowHold [ITI_CHANNELS];
    iti_mode_t   mode    [ITI_CHANNELS], next_mode    [ITI_CHANNELS];
    logic [1:0]  access  [ITI_CHANNELS], next_access  [ITI_CHANNELS];

    logic [2:0] bcd,         next_bcd;
    logic [2:0] latchValid,  next_latchValid;
    logic [2:0] readHigh,    next_readHigh;
    logic [2:0] writeHigh,   next_writeHigh;
    logic [2:0] loadPending, next_loadPending;
    logic [2:0] haveCount,   next_haveCount;
    logic [2:0] running,     next_running;
    logic [2:0] armed,       next_armed;
    logic [2:0] fired,       next_fired;
    logic [2:0] outLevel,    next_outLevel;
    logic [7:0] next_ioRdData;

    // ==========================================================
    // clock and gate edges
    wire  [2:0] tickLevel = {tickClock2, tickClock1, tickClock0};
    wire  [2:0] gateLevel = {triggerGate2, triggerGate1, triggerGate0};
    logic [2:0] tickFall;
    logic [2:0] gateRise;

    for (genvar ch = 0; ch < ITI_CHANNELS; ch++) begin : g_edges
        iti_edge_detect u_tick (
            .clk(clk), .srst(srst), .level(tickLevel[ch]),
            .rise(), .fall(tickFall[ch]));
        iti_edge_detect u_gate (
            .clk(clk), .srst(srst), .level(gateLevel[ch]),
            .rise(gateRise[ch]), .fall());
    end

    // ==========================================================
    // bus decode
    wire [7:0] addrLow   = ioAddr[7:0];
    wire       hiZero    = (ioAddr >> 8) == '0;
    wire [2:0] portHit   = {3{hiZero}} & {addrLow == ITI_ADDR_COUNT2,
                                          addrLow == ITI_ADDR_COUNT1,
                                          addrLow == ITI_ADDR_COUNT0};
    wire       ctrlHit   = hiZero && addrLow == ITI_ADDR_CTRL;
    wire [2:0] countWr   = portHit & {3{ioWrStrobe}};
    wire [2:0] countRd   = portHit & {3{ioRdStrobe}};
    wire       ctrlWrite = ctrlHit && ioWrStrobe;
    wire [1:0] cwSel     = ioWrData[ITI_SEL_HI:ITI_SEL_LO];
    wire [1:0] cwAcc     = ioWrData[ITI_ACC_HI:ITI_ACC_LO];
    wire [2:0] cwMode    = ioWrData[ITI_MODE_HI:ITI_MODE_LO];
    wire       cwBcd     = ioWrData[ITI_BCD_BIT];
    wire       cwValid   = ctrlWrite && cwSel != ITI_SEL_INVALID;
    wire       cwLatch   = cwValid && cwAcc == ITI_ACC_LATCH;
    wire       cwSetup   = cwValid && cwAcc != ITI_ACC_LATCH;
    wire iti_mode_t cwModeDec = iti_decode_mode(cwMode);

    // ==========================================================
    // next state of all channels
    always_comb begin
        logic [15:0] dec1;
        logic [15:0] dec2;
        logic [15:0] endVal;
        logic [15:0] loadVal;
        logic        loadDone;
        dec1     = ITI_ZERO;
        dec2     = ITI_ZERO;
        endVal   = ITI_ZERO;
        loadVal  = ITI_ZERO;
        loadDone = 1'b0;
        {next_bcd, next_latchValid, next_readHigh, next_writeHigh, next_loadPending} =
            {bcd, latchValid, readHigh, writeHigh, loadPending};
        {next_haveCount, next_running, next_armed, next_fired, next_outLevel} =
            {haveCount, running, armed, fired, outLevel};
        for (int i = 0; i < ITI_CHANNELS; i++) begin
            next_count[i]   = count[i];
            next_reload[i]  = reload[i];
            next_latched[i] = latched[i];
            next_lowHold[i] = lowHold[i];
            next_mode[i]    = mode[i];
            next_access[i]  = access[i];
            dec1     = iti_dec_one(count[i], bcd[i]);
            dec2     = iti_dec_one(dec1, bcd[i]);
            loadDone = 1'b0;
            loadVal  = reload[i];
            if (cwSetup && cwSel == 2'(i)) begin
                next_mode[i]        = cwModeDec;
                next_bcd[i]         = cwBcd;
                next_access[i]      = cwAcc;
                {next_running[i], next_loadPending[i], next_haveCount[i], next_armed[i]} = 4'h0;
                {next_fired[i], next_latchValid[i], next_readHigh[i], next_writeHigh[i]} = 4'h0;
                next_outLevel[i]    = cwModeDec != ITI_MODE_TERMINAL;
            end else begin
                if (cwLatch && cwSel == 2'(i) && !latchValid[i]) begin
                    next_latched[i]    = count[i];
                    next_latchValid[i] = 1'b1;
                end
                if (countRd[i]) begin
                    if (access[i] == ITI_ACC_BOTH && !readHigh[i]) begin
                        next_readHigh[i] = 1'b1;
                    end else begin
                        next_readHigh[i]   = 1'b0;
                        next_latchValid[i] = 1'b0;
                    end
                end
                if (countWr[i]) begin
                    unique case (access[i])
                        ITI_ACC_LOW: begin
                            loadVal  = {ITI_BYTE_ZERO, ioWrData};
                            loadDone = 1'b1;
                        end
                        ITI_ACC_HIGH: begin
                            loadVal  = {ioWrData, ITI_BYTE_ZERO};
                            loadDone = 1'b1;
                        end
                        ITI_ACC_BOTH: begin
                            if (!writeHigh[i]) begin
                                next_lowHold[i]   = ioWrData;
                                next_writeHigh[i] = 1'b1;
                            end else begin
                                loadVal           = {ioWrData, lowHold[i]};
                                next_writeHigh[i] = 1'b0;
                                loadDone          = 1'b1;
                            end
                        end
                        default: ;
                    endcase
                    if (loadDone) begin
                        next_reload[i]      = loadVal;
                        next_loadPending[i] = 1'b1;
                        next_haveCount[i]   = 1'b1;
                        if (mode[i] == ITI_MODE_TERMINAL) begin
                            next_outLevel[i] = 1'b0;
                        end
                    end
                end else begin
                    if (gateRise[i] && haveCount[i]) begin
                        next_armed[i] = 1'b1;
                    end
                    if (tickFall[i]) begin
                        unique case (mode[i])
                            ITI_MODE_TERMINAL, ITI_MODE_SW_STROBE: begin
                                if (loadPending[i]) begin
                                    next_count[i]       = reload[i];
                                    next_loadPending[i] = 1'b0;
                                    next_running[i]     = 1'b1;
                                    next_fired[i]       = 1'b0;
                                end else if (running[i]) begin
                                    next_count[i] = dec1;
                                    if (mode[i] == ITI_MODE_TERMINAL) begin
                                        if (dec1 == ITI_ZERO) begin
                                            next_outLevel[i] = 1'b1;
                                        end
                                    end else if (dec1 == ITI_ZERO && !fired[i]) begin
                                        next_outLevel[i] = 1'b0;
                                        next_fired[i]    = 1'b1;
                                    end else begin
                                        next_outLevel[i] = 1'b1;
                                    end
                                end
                            end
                            ITI_MODE_ONE_SHOT, ITI_MODE_HW_STROBE: begin
                                if (armed[i]) begin
                                    next_count[i]       = reload[i];
                                    next_armed[i]       = 1'b0;
                                    next_loadPending[i] = 1'b0;
                                    next_running[i]     = 1'b1;
                                    next_fired[i]       = 1'b0;
                                    next_outLevel[i]    = mode[i] != ITI_MODE_ONE_SHOT;
                                end else if (running[i]) begin
                                    next_count[i] = dec1;
                                    if (mode[i] == ITI_MODE_ONE_SHOT) begin
                                        if (dec1 == ITI_ZERO) begin
                                            next_outLevel[i] = 1'b1;
                                        end
                                    end else if (dec1 == ITI_ZERO && !fired[i]) begin
                                        next_outLevel[i] = 1'b0;
                                        next_fired[i]    = 1'b1;
                                    end else begin
                                        next_outLevel[i] = 1'b1;
                                    end
                                end
                            end
                            ITI_MODE_RATE: begin
                                if (loadPending[i] || (running[i] && count[i] == ITI_ONE)) begin
                                    next_count[i]       = reload[i];
                                    next_loadPending[i] = 1'b0;
                                    next_running[i]     = 1'b1;
                                    next_outLevel[i]    = 1'b1;
                                end else if (running[i]) begin
                                    next_count[i]    = dec1;
                                    next_outLevel[i] = dec1 != ITI_ONE;
                                end
                            end
                            ITI_MODE_SQUARE: begin
                                endVal = !reload[i][0] ? ITI_TWO :
                                         (outLevel[i] ? ITI_ONE : ITI_THREE);
                                if (loadPending[i]) begin
                                    next_count[i]       = reload[i];
                                    next_loadPending[i] = 1'b0;
                                    next_running[i]     = 1'b1;
                                    next_outLevel[i]    = 1'b1;
                                end else if (running[i]) begin
                                    if (count[i] == endVal) begin
                                        next_count[i]    = reload[i];
                                        next_outLevel[i] = !outLevel[i];
                                    end else begin
                                        next_count[i] = dec2;
                                    end
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
        end
    end

    // ==========================================================
    // read data
    always_comb begin
        logic [15:0] src;
        logic        takeHigh;
        src           = ITI_ZERO;
        takeHigh      = 1'b0;
        next_ioRdData = ITI_BYTE_ZERO;
        if (ctrlHit) begin
            next_ioRdData = ITI_CTRL_READ;
        end
        for (int i = 0; i < ITI_CHANNELS; i++) begin
            src      = latchValid[i] ? latched[i] : count[i];
            takeHigh = access[i] == ITI_ACC_HIGH ||
                       (access[i] == ITI_ACC_BOTH && readHigh[i]);
            if (portHit[i]) begin
                next_ioRdData = takeHigh ? src[15:8] : src[7:0];
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < ITI_CHANNELS; i++) begin
                count[i]   <= ITI_ZERO;
                reload[i]  <= ITI_ZERO;
                latched[i] <= ITI_ZERO;
                lowHold[i] <= ITI_BYTE_ZERO;
                mode[i]    <= ITI_MODE_TERMINAL;
                access[i]  <= ITI_ACC_BOTH;
            end
            {bcd, latchValid, readHigh, writeHigh, loadPending} <= '0;
            {haveCount, running, armed, fired, outLevel}        <= '0;
            ioRdData  <= ITI_BYTE_ZERO;
            ioRdValid <= 1'b0;
        end else begin
            count       <= next_count;
            reload      <= next_reload;
            latched     <= next_latched;
            lowHold     <= next_lowHold;
            mode        <= next_mode;
            access      <= next_access;
            {bcd, latchValid, readHigh, writeHigh, loadPending} <=
                {next_bcd, next_latchValid, next_readHigh, next_writeHigh, next_loadPending};
            {haveCount, running, armed, fired, outLevel} <=
                {next_haveCount, next_running, next_armed, next_fired, next_outLevel};
            ioRdData    <= ioRdStrobe ? next_ioRdData : ioRdData;
            ioRdValid   <= ioRdStrobe;
        end
    end

    assign terminalCountOutput = outLevel[0];
    assign interruptInputSix   = outLevel[0];
    assign baudClockA          = outLevel[1];
    assign baudClockB          = outLevel[2];

endmodule // iti_interval_timer

/* File: tb/iti_interval_timer_chk.sv */
module iti_interval_timer_chk
    import iti_pkg::*;
#(parameter int ADDR_WIDTH = 8)
(
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic [ADDR_WIDTH-1:0] ioAddr,
    input wire logic                  ioWrStrobe,
    input wire logic                  ioRdStrobe,
    input wire logic [7:0]            ioWrData,
    input wire logic [7:0]            ioRdData,
    input wire logic                  ioRdValid,
    input wire logic                  tickClock0,
    input wire logic                  terminalCountOutput,
    input wire logic                  interruptInputSix
);
    // ==========
    // port checks
    wire logic ctrlWr  = ioWrStrobe && ioAddr == ITI_ADDR_CTRL;
    wire logic sel0Wr  = ctrlWr && ioWrData[7:6] == 2'h0;
    wire logic initTc  = sel0Wr && ioWrData[5:4] != ITI_ACC_LATCH && ioWrData[3:1] == 3'h0;
    wire logic reload0 = sel0Wr || (ioWrStrobe && ioAddr == ITI_ADDR_COUNT0);
    logic      tcMode0;
    // counter 0 mode tracking, mode 0 from reset
    always_ff @(posedge clk) begin
        if (srst) begin
            tcMode0 <= 1'b1;
        end else if (sel0Wr && ioWrData[5:4] != ITI_ACC_LATCH) begin
            tcMode0 <= initTc;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_rd_answer: assert property (ioRdStrobe |=> ioRdValid) else $error("no answer");
    a_rd_pulse: assert property (!ioRdStrobe |=> !ioRdValid) else $error("stray valid");
    a_rd_hold: assert property (!ioRdStrobe |=> $stable(ioRdData)) else $error("data moved");
    a_ctrl_read: assert property (ioRdStrobe && ioAddr == ITI_ADDR_CTRL |=>
        ioRdData == ITI_CTRL_READ) else $error("setup read value");
    a_irq_tie: assert property (interruptInputSix == terminalCountOutput) else $error("irq");
    a_setup_low: assert property (initTc |=> !terminalCountOutput) else $error("not low");
    a_tc_held: assert property (tcMode0 && terminalCountOutput && !reload0 |=>
        terminalCountOutput)
        else $error("output dropped");
    a_tc_tick: assert property (tcMode0 && $rose(terminalCountOutput) |->
        $past(tickClock0, 2) && !$past(tickClock0)) else $error("rise without tick");
    cover property ($rose(terminalCountOutput));
    cover property (ctrlWr && ioWrData[7:6] == ITI_SEL_INVALID);
    cover property (ioRdStrobe && ioAddr == ITI_ADDR_CTRL);
endmodule // iti_interval_timer_chk

bind iti_interval_timer iti_interval_timer_chk #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (
    .clk(clk), .srst(srst), .ioAddr(ioAddr), .ioWrStrobe(ioWrStrobe),
    .ioRdStrobe(ioRdStrobe), .ioWrData(ioWrData), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .tickClock0(tickClock0),
    .terminalCountOutput(terminalCountOutput), .interruptInputSix(interruptInputSix));

/* File: tb/iti_host_model.sv */
module iti_host_model
(
    input  wire logic       clk,
    output logic      [7:0] ioAddr,
    output logic            ioWrStrobe,
    output logic            ioRdStrobe,
    output logic      [7:0] ioWrData,
    input  wire logic [7:0] ioRdData,
    input  wire logic       ioRdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // host bus cycles
    initial begin
        ioAddr = 8'h00;
        ioWrData = 8'h00;
        ioWrStrobe = 1'b0;
        ioRdStrobe = 1'b0;
    end
    // callers give setup word first, two-byte counts low byte first
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 ioAddr = a;
        ioWrData = d;
        ioWrStrobe = 1'b1;
        @(posedge clk);
        #1 ioWrStrobe = 1'b0;
        ioWrData = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        #1 ioAddr = a;
        ioRdStrobe = 1'b1;
        @(posedge clk);
        #1 ioRdStrobe = 1'b0;
        v = ioRdValid;
        d = ioRdData;
    endtask
endmodule // iti_host_model

/* File: tb/tb_iti_interval_timer.sv */
module tb_iti_interval_timer
    import iti_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk, srst, tick, ioWrStrobe, ioRdStrobe, ioRdValid, tcOut, irqSix, baudA, baudB;
    logic [7:0] ioAddr, ioWrData, ioRdData;
    int         errCount, samplesChecked;
    iti_interval_timer dut (.clk(clk), .srst(srst), .ioAddr(ioAddr), .ioWrStrobe(ioWrStrobe),
        .ioRdStrobe(ioRdStrobe), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid),
        .tickClock0(tick), .tickClock1(tick), .tickClock2(tick), .triggerGate0(1'b0),
        .triggerGate1(1'b0), .triggerGate2(1'b0), .terminalCountOutput(tcOut),
        .interruptInputSix(irqSix), .baudClockA(baudA), .baudClockB(baudB));
    iti_host_model host (.clk(clk), .ioAddr(ioAddr), .ioWrStrobe(ioWrStrobe),
        .ioRdStrobe(ioRdStrobe), .ioWrData(ioWrData), .ioRdData(ioRdData), .ioRdValid(ioRdValid));
    // ==========
    // helpers
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samplesChecked++;
        if (g !== e) begin
            errCount++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        host.rd(a, d, v);
        chk("read valid", 16'h0001, {15'h0000, v});
        chk("read data", {8'h00, e}, {8'h00, d});
    endtask
    task automatic tc(input logic e);
        chk("terminal output", {15'h0000, e}, {15'h0000, tcOut});
        chk("interrupt six", {15'h0000, e}, {15'h0000, irqSix});
    endtask
    // all three counters step on the falling change; 2 cycles high, at least 3 low
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 tick = 1'b1;
            repeat (2) @(posedge clk);
            #1 tick = 1'b0;
            repeat (2) @(posedge clk);
            #2;
        end
    endtask
    task automatic highs(input logic b, input int n, input int e);
        int h;
        h = 0;
        repeat (n) begin
            ticks(1);
            h += b ? int'(baudB) : int'(baudA);
        end
        chk("high ticks", 16'(e), 16'(h));
    endtask
    // ==========
    // scenarios
    task automatic s_mode0;
        host.wr(ITI_ADDR_CTRL, 8'h30);
        host.wr(ITI_ADDR_COUNT0, 8'h03);
        ticks(1);
        host.wr(ITI_ADDR_COUNT0, 8'h00);
        ticks(3);
        tc(1'b0);
        ticks(1);
        tc(1'b1);
        ticks(1);
        host.wr(ITI_ADDR_CTRL, 8'h00);
        ticks(1);
        rdc(ITI_ADDR_COUNT0, 8'hFF);
        rdc(ITI_ADDR_COUNT0, 8'hFF);
        rdc(ITI_ADDR_COUNT0, 8'hFE);
        rdc(ITI_ADDR_COUNT0, 8'hFF);
        host.wr(ITI_ADDR_CTRL, 8'hF0);
        tc(1'b1);
        host.wr(ITI_ADDR_CTRL, 8'h31);
        tc(1'b0);
        host.wr(ITI_ADDR_COUNT0, 8'h01);
        host.wr(ITI_ADDR_COUNT0, 8'h00);
        ticks(3);
        tc(1'b1);
        rdc(ITI_ADDR_COUNT0, 8'h99);
        rdc(ITI_ADDR_COUNT0, 8'h99);
    endtask
    task automatic s_square;
        host.wr(ITI_ADDR_CTRL, 8'h66);
        host.wr(ITI_ADDR_COUNT1, 8'h04);
        highs(1'b0, 8, 4);
        host.wr(ITI_ADDR_CTRL, 8'hAE);
        host.wr(ITI_ADDR_COUNT2, 8'h05);
        highs(1'b1, 10, 6);
    endtask
    task automatic s_refused;
        rdc(ITI_ADDR_CTRL, ITI_CTRL_READ);
        rdc(8'h60, ITI_BYTE_ZERO);
    endtask
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (5000) @(posedge clk);
        errCount++;
        reportAndStop();
    end
    initial begin
        srst = 1'b1;
        tick = 1'b0;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        s_mode0();
        s_square();
        s_refused();
        reportAndStop();
    end
endmodule // tb_iti_interval_timer
